// [hw/sac_params.svh]
/*
 * Constants of the converter control block: field positions, reset values,
 * conversion and sampling counts, and the power settle time.
 * Assumes the including file runs on a 100 MHz clock that also serves as
 * the converter clock, so one converter clock period is one clk cycle.
 */
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// ==========================================================================
// Field positions
`define SAC_MODE_RUN_BIT      7
`define SAC_MODE_SPEED_HI     5
`define SAC_MODE_SPEED_LO     3
`define SAC_MODE_POWER_BIT    0
`define SAC_CHAN_HI           2
`define SAC_CMP_EN_BIT        7
`define SAC_CMP_COND_BIT      6
`define SAC_RES_BITS          10
`define SAC_RES_ZERO_BITS     6
`define SAC_REG_BITS          16

// ==========================================================================
// Reset values
`define SAC_REG_RESET         8'h00
`define SAC_RESULT_RESET      16'h0000

// ==========================================================================
// Conversion and sampling time per speed code, in converter clocks
`define SAC_CONV_SPEED0       9'd288
`define SAC_CONV_SPEED1       9'd240
`define SAC_CONV_SPEED2       9'd192
`define SAC_CONV_SPEED4       9'd144
`define SAC_CONV_SPEED5       9'd120
`define SAC_CONV_SPEED6       9'd96
`define SAC_SAMP_SPEED0       6'd40
`define SAC_SAMP_SPEED1       6'd32
`define SAC_SAMP_SPEED2       6'd24
`define SAC_SAMP_SPEED4       6'd20
`define SAC_SAMP_SPEED5       6'd16
`define SAC_SAMP_SPEED6       6'd12

// ==========================================================================
// Power settle time
`define SAC_CLK_PERIOD_NS     10
`define SAC_SETTLE_NS         14000
`define SAC_SETTLE_CYCLES     ((`SAC_SETTLE_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_SETTLE_W          11

`endif

// [hw/sac_pkg.sv]
/*
 * Types shared by the converter control block and its sequencer.
 * Assumes sac_params.svh is available on the include path.
 */
package sac_pkg;

    // ======================================================================
    // Sequencer states
    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_CONVERT,
        SAC_FINISH
    } sac_state_e;

    // ======================================================================
    // Register write port: one strobe per register, shared data byte
    typedef struct packed {
        logic       mode_wr;
        logic       chan_wr;
        logic       cmp_wr;
        logic       thr_wr;
        logic [7:0] data;
    } sac_wr_s;

    // ======================================================================
    // Conversion timing handed to the sequencer
    typedef struct packed {
        logic [8:0] conv;
        logic [5:0] samp;
    } sac_timing_s;

endpackage : sac_pkg

// [hw/sac_seq.sv]
/*
 * Successive-approximation sequencer: sampling phase, ten bit trials and a
 * wait to the end of the programmed conversion time, then a done pulse.
 * Assumes an external comparator answers the tap within one clk cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"

module sac_seq (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 run,
    input  wire logic                 restart,
    input  wire sac_pkg::sac_timing_s timing,
    input  wire logic                 cmp_in,
    output logic [9:0]                sar_tap,
    output logic                      sample_hold,
    output logic                      done,
    output logic [9:0]                result,
    output logic                      busy
);

    sac_pkg::sac_state_e state;
    sac_pkg::sac_state_e next_state;
    logic [8:0]          cnt;
    logic [9:0]          sar;
    logic [3:0]          bit_idx;
    wire                 last_cycle = (cnt == timing.conv - 9'd1);
    wire                 samp_end   = (cnt == {3'h0, timing.samp} - 9'd1);
    wire                 trial_end  = (bit_idx == 4'h0);

    always_comb begin
        next_state = state;
        case (state)
            sac_pkg::SAC_IDLE:    next_state = sac_pkg::SAC_SAMPLE;
            sac_pkg::SAC_SAMPLE:  if (samp_end) next_state = sac_pkg::SAC_CONVERT;
            sac_pkg::SAC_CONVERT: if (trial_end) next_state = sac_pkg::SAC_FINISH;
            sac_pkg::SAC_FINISH:  if (last_cycle) next_state = sac_pkg::SAC_SAMPLE;
            default:              next_state = sac_pkg::SAC_IDLE;
        endcase
    end

    // A cleared run bit or a restart request throws the conversion away.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state       <= sac_pkg::SAC_IDLE;
            cnt         <= 9'h000;
            sar         <= 10'h000;
            bit_idx     <= 4'h0;
            sar_tap     <= 10'h000;
            sample_hold <= 1'b0;
            done        <= 1'b0;
            result      <= 10'h000;
        end else if (!run) begin
            state       <= sac_pkg::SAC_IDLE;
            cnt         <= 9'h000;
            sample_hold <= 1'b0;
            done        <= 1'b0;
        end else if (restart || state == sac_pkg::SAC_IDLE) begin
            state       <= sac_pkg::SAC_SAMPLE;
            cnt         <= 9'h000;
            sample_hold <= 1'b1;
            done        <= 1'b0;
        end else begin
            state       <= next_state;
            cnt         <= last_cycle ? 9'h000 : cnt + 9'd1;
            done        <= (state == sac_pkg::SAC_FINISH) && last_cycle;
            sample_hold <= (next_state == sac_pkg::SAC_SAMPLE);
            if (state == sac_pkg::SAC_SAMPLE && samp_end) begin
                sar     <= 10'h200;
                sar_tap <= 10'h200;
                bit_idx <= 4'd9;
            end else if (state == sac_pkg::SAC_CONVERT) begin
                // Keep the trial bit when the input is at or above the tap.
                sar[bit_idx] <= cmp_in;
                if (!trial_end) begin
                    sar[bit_idx - 4'd1]     <= 1'b1;
                    sar_tap                 <= sar;
                    sar_tap[bit_idx]        <= cmp_in;
                    sar_tap[bit_idx - 4'd1] <= 1'b1;
                    bit_idx                 <= bit_idx - 4'd1;
                end else begin
                    result     <= sar;
                    result[0]  <= cmp_in;
                end
            end
        end
    end

    assign busy = (state != sac_pkg::SAC_IDLE);

endmodule : sac_seq

`default_nettype wire

// [hw/sac_top.sv]
/*
 * Control of an eight-input 10-bit successive-approximation converter with
 * a threshold compare mode that gates the conversion-end pulse.
 * Assumes software writes registers through one-cycle strobes on the write
 * port and signals a result read with a one-cycle strobe; the analog mux,
 * tap ladder and comparator sit outside.
 */
// Operation
// (RULE1) Result stored as conversion value times 64.
// (RULE2) One of eight inputs, channel bits 2..0.
// (RULE3) Compare-mode bit 7 selects plain or compare.
// (RULE4) Setting run bit starts conversion.
// (RULE5) Plain mode: store every result, pulse end.
// (RULE6) Next conversion starts immediately while running.
// (RULE7) Register write aborts, restarts if still running.
// (RULE8) Clearing run bit stops conversion at once.
// (RULE9) Condition 0: pulse when upper byte >= threshold.
// (RULE10) Condition 1: pulse when below; always store.
// (RULE11) Unread result is overwritten by newer one.
// (RULE12) Software waits 14 us after power enable.
// (RULE13) Speed field bits 5..3 sets conversion time.
// (RULE14) Skipping power step: discard first result.
// (RULE15) Compare use needs power and 14 us.
// (RULE16) Channel change gives full conversion time.
// (RULE17) Result is 10 bits, 1024 codes.
// (RULE18) Low six result bits read zero.
// (RULE19) Mode/channel write beats end: nothing stored.
// (RULE20) Read beats end: store one cycle later.
// (RULE21) Threshold compare is unsigned.
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"

module sac_top (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire sac_pkg::sac_wr_s wr,
    input  wire logic             result_rd,
    input  wire logic             cmp_in,
    output logic [7:0]            conv_mode_reg,
    output logic [7:0]            channel_select_reg,
    output logic [7:0]            compare_mode_reg,
    output logic [7:0]            compare_threshold_reg,
    output logic [15:0]           conv_result_reg,
    output logic                  conv_end_irq,
    output logic [2:0]            analog_inputs,
    output logic [9:0]            sar_tap,
    output logic                  sample_hold,
    output logic                  conv_power_enable,
    output logic                  power_settled
);

    // ======================================================================
    // Speed decode
    function automatic sac_pkg::sac_timing_s speed_timing(input logic [2:0] code);
        sac_pkg::sac_timing_s t;
        t.conv = `SAC_CONV_SPEED0;
        t.samp = `SAC_SAMP_SPEED0;
        case (code)
            3'h1: begin
                t.conv = `SAC_CONV_SPEED1;
                t.samp = `SAC_SAMP_SPEED1;
            end
            3'h2: begin
                t.conv = `SAC_CONV_SPEED2;
                t.samp = `SAC_SAMP_SPEED2;
            end
            3'h4: begin
                t.conv = `SAC_CONV_SPEED4;
                t.samp = `SAC_SAMP_SPEED4;
            end
            3'h5: begin
                t.conv = `SAC_CONV_SPEED5;
                t.samp = `SAC_SAMP_SPEED5;
            end
            3'h6: begin
                t.conv = `SAC_CONV_SPEED6;
                t.samp = `SAC_SAMP_SPEED6;
            end
            default: begin
                t.conv = `SAC_CONV_SPEED0;
                t.samp = `SAC_SAMP_SPEED0;
            end
        endcase
        return t;
    endfunction : speed_timing

    // ======================================================================
    // Register writes
    wire any_wr      = wr.mode_wr | wr.chan_wr | wr.cmp_wr | wr.thr_wr;
    wire ctl_wr      = wr.mode_wr | wr.chan_wr;
    wire conv_run    = conv_mode_reg[`SAC_MODE_RUN_BIT];
    wire compare_enable    = compare_mode_reg[`SAC_CMP_EN_BIT];
    wire compare_condition = compare_mode_reg[`SAC_CMP_COND_BIT];
    // Reserved mode bits are dropped here so they always read as zero.
    wire [7:0] mode_wval = {wr.data[`SAC_MODE_RUN_BIT], 1'b0,
                            wr.data[`SAC_MODE_SPEED_HI:`SAC_MODE_SPEED_LO],
                            2'b00, wr.data[`SAC_MODE_POWER_BIT]};

    // The restart pulse trails the write by one cycle, which is also the cycle
    // in which the new register values reach the sequencer.
    logic restart;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conv_mode_reg         <= `SAC_REG_RESET;
            channel_select_reg    <= `SAC_REG_RESET;
            compare_mode_reg      <= `SAC_REG_RESET;
            compare_threshold_reg <= `SAC_REG_RESET;
            restart               <= 1'b0;
        end else begin
            // (RULE4) Run bit write.
            if (wr.mode_wr)
                conv_mode_reg <= mode_wval;
            // (RULE2) Channel bits kept.
            if (wr.chan_wr)
                channel_select_reg <= {5'h00, wr.data[`SAC_CHAN_HI:0]};
            // (RULE3) Mode bits kept.
            if (wr.cmp_wr)
                compare_mode_reg <= {wr.data[`SAC_CMP_EN_BIT:`SAC_CMP_COND_BIT], 6'h00};
            if (wr.thr_wr)
                compare_threshold_reg <= wr.data;
            // (RULE7) Abort on write.
            restart <= any_wr;
        end
    end

    // Mux select and power enable are registered copies for the analog side.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            analog_inputs     <= 3'h0;
            conv_power_enable <= 1'b0;
        end else begin
            analog_inputs     <= channel_select_reg[`SAC_CHAN_HI:0];
            conv_power_enable <= conv_mode_reg[`SAC_MODE_POWER_BIT];
        end
    end

    // ======================================================================
    // Sequencer
    sac_pkg::sac_timing_s timing;
    logic                 done;
    logic [9:0]           seq_result;

    // (RULE13) Speed sets time.
    assign timing = speed_timing(conv_mode_reg[`SAC_MODE_SPEED_HI:`SAC_MODE_SPEED_LO]);

    // (RULE6) Continuous run; (RULE8) stop; (RULE16) full time after restart.
    sac_seq u_seq (
        .clk         (clk),
        .rstn        (rstn),
        .run         (conv_run),
        .restart     (restart),
        .timing      (timing),
        .cmp_in      (cmp_in),
        .sar_tap     (sar_tap),
        .sample_hold (sample_hold),
        .done        (done),
        .result      (seq_result),
        .busy        ()
    );

    // ======================================================================
    // Result store and end pulse
    // A result that meets a read is parked for a cycle so the read sees the old value.
    logic       pend;
    logic [9:0] pend_val;

    // (RULE19) Control write wins.
    wire        end_ok    = done & ~ctl_wr;
    // (RULE20) Read delays store.
    wire        store_now = (end_ok & ~result_rd) | (pend & ~result_rd);
    wire [9:0]  store_val = pend ? pend_val : seq_result;
    // (RULE21) Unsigned upper byte compare.
    wire        at_or_above = (store_val[9:2] >= compare_threshold_reg);
    // (RULE5) Plain mode pulses; (RULE9) (RULE10) compare gating.
    wire        irq_ok = ~compare_enable | (compare_condition ? ~at_or_above : at_or_above);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend            <= 1'b0;
            pend_val        <= 10'h000;
            conv_result_reg <= `SAC_RESULT_RESET;
            conv_end_irq    <= 1'b0;
        end else begin
            if (end_ok && result_rd) begin
                pend     <= 1'b1;
                pend_val <= seq_result;
            end else if (store_now) begin
                pend     <= 1'b0;
            end
            // (RULE1) (RULE17) (RULE18) Times 64; (RULE11) overwrite.
            if (store_now)
                conv_result_reg <= {store_val, {`SAC_RES_ZERO_BITS{1'b0}}};
            conv_end_irq <= store_now & irq_ok;
        end
    end

    // ======================================================================
    // Power settle status
    logic [`SAC_SETTLE_W-1:0] settle_cnt;

    // Status only: nothing stops software from setting run before this flag.
    // (RULE12) (RULE15) Settle time flag.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            settle_cnt    <= '0;
            power_settled <= 1'b0;
        end else if (!conv_mode_reg[`SAC_MODE_POWER_BIT]) begin
            settle_cnt    <= '0;
            power_settled <= 1'b0;
        end else if (settle_cnt != `SAC_SETTLE_W'(`SAC_SETTLE_CYCLES)) begin
            settle_cnt    <= settle_cnt + `SAC_SETTLE_W'(1);
        end else begin
            power_settled <= 1'b1;
        end
    end

endmodule : sac_top

`default_nettype wire

// [testbench/sac_chk.sv]
/* Assertion checker for the converter control ports, bound into sac_top.
   Assumes one clock and the active-low asynchronous reset of sac_top. */
`timescale 1ns/1ps
`default_nettype none
module sac_chk (
    input wire logic             clk,
    input wire logic             rstn,
    input wire sac_pkg::sac_wr_s wr,
    input wire logic             result_rd,
    input wire logic [7:0]       conv_mode_reg,
    input wire logic [7:0]       channel_select_reg,
    input wire logic [7:0]       compare_mode_reg,
    input wire logic [7:0]       compare_threshold_reg,
    input wire logic [15:0]      conv_result_reg,
    input wire logic             conv_end_irq,
    input wire logic [2:0]       analog_inputs,
    input wire logic             sample_hold
);
    localparam int CT [8] = '{288, 240, 192, 288, 144, 120, 96, 288};
    logic [9:0] gap;
    logic       dirty;
    logic       clean;
    logic       any_wr;
    // Pulse spacing is only judged when no write or read disturbed two intervals.
    assign any_wr = wr.mode_wr | wr.chan_wr | wr.cmp_wr | wr.thr_wr;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap   <= 10'h000;
            dirty <= 1'b1;
            clean <= 1'b0;
        end else if (conv_end_irq) begin
            gap   <= 10'h001;
            clean <= !dirty;
            dirty <= any_wr | result_rd;
        end else begin
            gap   <= gap + 10'h001;
            dirty <= dirty | any_wr | result_rd;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_low_zero: assert property (conv_result_reg[5:0] == 6'h00)
        else $error("result low bits not zero");
    a_irq_single: assert property (conv_end_irq |=> !conv_end_irq)
        else $error("end pulse longer than one cycle");
    a_plain_store: assert property ($changed(conv_result_reg) && !compare_mode_reg[7] |-> conv_end_irq)
        else $error("plain result stored without end pulse");
    a_ge_gate: assert property (conv_end_irq && compare_mode_reg[7:6] == 2'b10
        |-> conv_result_reg[15:8] >= compare_threshold_reg)
        else $error("pulse while result below threshold");
    a_lt_gate: assert property (conv_end_irq && compare_mode_reg[7:6] == 2'b11
        |-> conv_result_reg[15:8] < compare_threshold_reg)
        else $error("pulse while result not below threshold");
    a_write_abort: assert property (wr.mode_wr || wr.chan_wr |=> !conv_end_irq [*8])
        else $error("end pulse after mode or channel write");
    a_stop_quiet: assert property ($fell(conv_mode_reg[7]) |-> !conv_end_irq [*8])
        else $error("end pulse after run cleared");
    a_sample_chan: assert property ($rose(sample_hold) |-> analog_inputs == channel_select_reg[2:0])
        else $error("sampling a channel other than selected");
    a_irq_spacing: assert property (conv_end_irq && clean && !dirty && !compare_mode_reg[7]
        |-> gap == CT[conv_mode_reg[5:3]])
        else $error("end pulse spacing differs from conversion time");
endmodule : sac_chk
bind sac_top sac_chk u_chk (.clk, .rstn, .wr, .result_rd, .conv_mode_reg, .channel_select_reg,
    .compare_mode_reg, .compare_threshold_reg, .conv_result_reg, .conv_end_irq,
    .analog_inputs, .sample_hold);
`default_nettype wire

// [testbench/sac_front.sv]
/* Front-end model: eight input levels, the analog mux and the comparator.
   Assumes the bench gives each level as an ideal 10-bit code. */
`timescale 1ns/1ps
`default_nettype none
module sac_front (
    input  wire logic [7:0][9:0] levels,
    input  wire logic [2:0]      analog_inputs,
    input  wire logic [9:0]      sar_tap,
    output logic                 cmp_in
);
    assign cmp_in = levels[analog_inputs] >= sar_tap;
endmodule : sac_front
`default_nettype wire

// [testbench/tb_top.sv]
/* Self-checking bench for sac_top driving register strobes and input levels.
   Assumes sac_pkg, sac_chk and sac_front are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic             clk;
    logic             rstn;
    sac_pkg::sac_wr_s wr;
    logic             result_rd;
    logic             cmp_in;
    logic [7:0]       conv_mode_reg;
    logic [7:0]       channel_select_reg;
    logic [7:0]       compare_mode_reg;
    logic [7:0]       compare_threshold_reg;
    logic [15:0]      conv_result_reg;
    logic             conv_end_irq;
    logic [2:0]       analog_inputs;
    logic [9:0]       sar_tap;
    logic             power_settled;
    logic             conv_power_enable;
    logic [7:0][9:0]  levels;
    int               fail_count;
    int               n_compared;
    int               ct [8] = '{288, 240, 192, 288, 144, 120, 96, 288};

    sac_top dut (.clk, .rstn, .wr, .result_rd, .cmp_in, .conv_mode_reg, .channel_select_reg,
        .compare_mode_reg, .compare_threshold_reg, .conv_result_reg, .conv_end_irq,
        .analog_inputs, .sar_tap, .sample_hold(), .conv_power_enable, .power_settled);
    sac_front u_front (.levels, .analog_inputs, .sar_tap, .cmp_in);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // Register 0 mode, 1 channel, 2 compare mode, 3 threshold; one idle cycle follows.
    task automatic wr_reg(input int r, input logic [7:0] d);
        wr = {4'b1000 >> r, d};
        tick(1);
        wr = '0;
        tick(1);
    endtask : wr_reg
    task automatic wait_irq(input int lim, output int k);
        k = 0;
        do begin
            tick(1);
            k++;
        end while (conv_end_irq !== 1'b1 && k < lim);
        if (conv_end_irq !== 1'b1) begin
            fail_count++;
            close_out();
        end
    endtask : wait_irq

    task automatic s_regs();
        check(16'(compare_mode_reg), 16'h0000);
        wr_reg(0, 8'h7e);
        check(16'(conv_mode_reg), 16'h0038);
        check(16'(conv_power_enable), 16'h0000);
        wr_reg(1, 8'hff);
        check(16'(channel_select_reg), 16'h0007);
        wr_reg(2, 8'hff);
        check(16'(compare_mode_reg), 16'h00c0);
        wr_reg(3, 8'h80);
        check(16'(compare_threshold_reg), 16'h0080);
        wr_reg(2, 8'h00);
        wr_reg(0, 8'h01);
        tick(1380);
        check(16'(power_settled), 16'h0000);
        check(16'(conv_power_enable), 16'h0001);
        tick(30);
        check(16'(power_settled), 16'h0001);
    endtask : s_regs
    task automatic s_plain(input int sp, input int ch);
        int k;
        wr_reg(1, 8'(ch));
        wr_reg(0, 8'h81 | 8'(sp << 3));
        wait_irq(ct[sp] + 8, k);
        check(conv_result_reg, {levels[ch], 6'h00});
        wait_irq(ct[sp] + 8, k);
        check(16'(k), 16'(ct[sp]));
    endtask : s_plain
    task automatic s_collide();
        int k;
        levels[1] = 10'h2a5;
        wait_irq(200, k);
        wait_irq(200, k);
        check(conv_result_reg, 16'ha940);
        levels[1] = 10'h15a;
        tick(ct[6] - 1);
        result_rd = 1'b1;
        tick(1);
        result_rd = 1'b0;
        check(16'(conv_end_irq), 16'h0000);
        check(conv_result_reg, 16'ha940);
        tick(1);
        check(16'(conv_end_irq), 16'h0001);
        check(conv_result_reg, 16'h5680);
    endtask : s_collide
    task automatic s_stop();
        int k;
        tick(40);
        wr_reg(0, 8'h31);
        k = 0;
        repeat (600) begin
            tick(1);
            k += (conv_end_irq !== 1'b0);
        end
        check(16'(k), 16'h0000);
    endtask : s_stop
    task automatic s_chan();
        int k;
        wr_reg(1, 8'h00);
        wr_reg(0, 8'h91);
        wait_irq(ct[2] + 8, k);
        check(conv_result_reg, 16'hffc0);
        tick(60);
        wr_reg(1, 8'h04);
        wait_irq(ct[2] + 8, k);
        check(16'(k), 16'(ct[2] + 1));
        check(conv_result_reg, {levels[4], 6'h00});
    endtask : s_chan
    task automatic s_cmp(input logic cond, input logic [7:0] up, input logic hit);
        int k;
        levels[4] = {up, 2'b11};
        wr_reg(2, {1'b1, cond, 6'h00});
        k = 0;
        repeat (220) begin
            tick(1);
            k += (conv_end_irq !== 1'b0);
        end
        check(16'(k != 0), 16'(hit));
        check(conv_result_reg, {up, 8'hc0});
    endtask : s_cmp

    initial begin
        rstn = 1'b0;
        wr = '0;
        result_rd = 1'b0;
        fail_count = 0;
        n_compared = 0;
        for (int i = 0; i < 8; i++) levels[i] = 10'(i * 131 + 5);
        levels[0] = 10'h3ff;
        tick(8);
        rstn = 1'b1;
        s_regs();
        for (int i = 0; i < 7; i++) if (i != 3) s_plain(i, 7 - i);
        s_collide();
        s_stop();
        s_chan();
        wr_reg(0, 8'hb1);
        s_cmp(1'b0, 8'h80, 1'b1);
        s_cmp(1'b0, 8'h7f, 1'b0);
        s_cmp(1'b1, 8'h7f, 1'b1);
        s_cmp(1'b1, 8'h80, 1'b0);
        rstn = 1'b0;
        tick(2);
        check(16'(conv_mode_reg), 16'h0000);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
